/* File: hw/io_channel_ctrl.sv */
// Purpose: device controller end of the processor i/o bus, byte input
// Assumes: bus strobes come from logic on core_clk_in, one cycle each
// Notes: byte stream from the device is buffered in a 32 entry fifo
// Summary of operation
// RL1: low address bits pick the peripheral
// RL2: raise cycle request only inside request window
// RL3: drive address on address-in when granted
// RL4: function code driven with the address
// RL5: processor raises window again before service
// RL6: word output comes with data-out window
// RL7: decode order, start device, wait ready
// RL8: code 4 outputs word and increments it
// RL9: overflow carried on flag with flag window
// RL10: code 3: drive byte on data-in
// RL11: hold request while steps remain, else drop
// RL12: byte input: fetch address, write, fetch count
// RL13: flag after count fetch ends transfer, chaining
// RL14: search/translate steps precede the byte steps
// RL15: order byte: 3-bit and 5-bit fields, mask
// RL16: table address is base plus character
// RL17: first device order bit requests chaining
// RL18: start takes packet address on data-out window
// RL19: stop halts device, clears requests, idles
// RL20: count is negative length, zero ends
// RL21: interrupt when condition and mask overlap
// RL22: strobes are single-cycle synchronous pulses
`timescale 1ns/1ns

module io_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic wr_valid_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    output logic wr_ready_out,
    output logic rd_valid_out,
    output logic [WIDTH-1:0] rd_data_out,
    input wire logic rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    wire full_w = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    wire empty_w = (wr_ptr_r == rd_ptr_r);
    wire push_w = wr_valid_in && !full_w;
    wire pop_w = rd_ready_in && !empty_w;
    assign wr_ready_out = !full_w;
    assign rd_valid_out = !empty_w;
    assign rd_data_out = mem[rd_ptr_r[AW-1:0]];

    always_ff @(posedge clk_in) begin
        if (push_w) begin
            mem[wr_ptr_r[AW-1:0]] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (push_w) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop_w) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end
endmodule

module io_channel_ctrl
    import io_chan_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire logic [6:0] ctl_addr_in,
    input wire logic [2:0] subchan_in,
    input wire logic [1:0] dev_sel_in,
    input wire logic device_address_window_in,
    input wire logic request_window_in,
    input wire logic address_in_strobe_in,
    input wire logic data_in_strobe_in,
    input wire logic data_out_window_in,
    input wire logic io_flag_in,
    input wire logic io_flag_window_in,
    input wire logic grant_in,
    input wire logic [15:0] data_bus_in,
    output logic [15:0] data_bus_out,
    output logic data_bus_oe_n_out,
    output logic [2:0] function_code_out,
    output logic cycle_request_out,
    output logic [4:0] device_order_out,
    output logic chain_req_out,
    output logic device_start_out,
    output logic device_stop_out,
    input wire logic device_ready_in,
    input wire logic byte_valid_in,
    input wire logic [7:0] byte_in,
    output logic byte_ready_out,
    output logic busy_out,
    output logic done_out,
    output logic [7:0] condition_out,
    output logic interrupt_out,
    input wire logic interrupt_clear_in
);
    state_type state_r, state_nxt;
    phase_type phase_r, phase_nxt;
    logic [15:0] ea_r, ea_nxt, buf_addr_r, buf_nxt, stb_r, stb_nxt, ttb_r, ttb_nxt;
    logic [15:0] bus_out_r, bus_nxt;
    logic [7:0] char_r, char_nxt, mask_r, mask_nxt, cond_r, cond_nxt, cond_set;
    logic [2:0] coc_r, coc_nxt, fc_r, fc_nxt, flag_cnt_r, cnt_nxt;
    logic [4:0] doc_r, doc_nxt;
    logic oe_n_r, oe_n_nxt, start_r, start_nxt, stop_r, done_r, done_nxt, irq_r;
    logic pop_w;
    logic fifo_valid_w;
    logic [7:0] fifo_data_w;

    io_byte_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .wr_valid_in(byte_valid_in),
        .wr_data_in(byte_in),
        .wr_ready_out(byte_ready_out),
        .rd_valid_out(fifo_valid_w),
        .rd_data_out(fifo_data_w),
        .rd_ready_in(pop_w)
    );

    wire [3:0] daw_cmd_w = data_bus_in[CMD_HI:CMD_LO];
    wire daw_hit_w = device_address_window_in                 // RL22
        && data_bus_in[CTL_HI:CTL_LO] == ctl_addr_in
        && data_bus_in[SUB_HI:SUB_LO] == subchan_in
        && data_bus_in[DEV_HI:DEV_LO] == dev_sel_in;          // RL1
    wire start_cmd_w = daw_hit_w && daw_cmd_w == CMD_START && state_r == ST_IDLE;
    wire stop_cmd_w = daw_hit_w && daw_cmd_w == CMD_STOP;
    wire srch_en_w = coc_r == COC_SRCH || coc_r == COC_BOTH;
    wire xlat_en_w = coc_r == COC_XLAT || coc_r == COC_XLAT_INT || coc_r == COC_BOTH;
    wire [15:0] char_ext_w = {8'h00, char_r};
    wire [15:0] step_addr_w =                                 // RL12
        (phase_r == PH_W0) ? ea_r :
        (phase_r == PH_W3) ? ea_r + PKT_W3_OFS :
        (phase_r == PH_W4) ? ea_r + PKT_W4_OFS :
        (phase_r == PH_SRCH) ? stb_r + char_ext_w :          // RL16
        (phase_r == PH_XLAT) ? ttb_r + char_ext_w :          // RL16
        (phase_r == PH_W1) ? ea_r + PKT_W1_OFS :
        (phase_r == PH_WR) ? buf_addr_r : ea_r + PKT_W2_OFS;
    wire [2:0] step_fc_w =
        (phase_r == PH_W1 || phase_r == PH_W2) ? FC_FETCH_INC :
        (phase_r == PH_WR) ? FC_WRITE : FC_READ;
    wire step_more_w = phase_r != PH_W0 && phase_r != PH_W4 && phase_r != PH_W2;
    wire [7:0] sel_byte_w = step_addr_w[0] ? data_bus_in[7:0] : data_bus_in[15:8];
    wire [7:0] cond_clr_w = interrupt_clear_in ? RESET_BYTE : cond_r;

    assign cycle_request_out = request_window_in && (state_r == ST_REQ
        || state_r == ST_TAIL // RL5
        || (state_r == ST_DATA && phase_r != PH_WR && step_more_w)); // RL11
    assign data_bus_out = bus_out_r;
    assign data_bus_oe_n_out = oe_n_r;
    assign function_code_out = fc_r;
    assign device_order_out = doc_r;
    assign chain_req_out = doc_r[DOC_CHAIN_BIT];             // RL17
    assign device_start_out = start_r;
    assign device_stop_out = stop_r;
    assign busy_out = state_r != ST_IDLE;
    assign done_out = done_r;
    assign condition_out = cond_r;
    assign interrupt_out = irq_r;
    assign cond_nxt = cond_clr_w | cond_set;                  // set wins over clear

    always_comb begin
        state_nxt = state_r;
        phase_nxt = phase_r;
        ea_nxt = ea_r;
        buf_nxt = buf_addr_r;
        stb_nxt = stb_r;
        ttb_nxt = ttb_r;
        char_nxt = char_r;
        coc_nxt = coc_r;
        doc_nxt = doc_r;
        mask_nxt = mask_r;
        bus_nxt = bus_out_r;
        oe_n_nxt = 1'b1;
        fc_nxt = FC_NONE;
        cnt_nxt = flag_cnt_r;
        cond_set = RESET_BYTE;
        start_nxt = 1'b0;
        done_nxt = 1'b0;
        pop_w = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (start_cmd_w) begin
                    state_nxt = ST_GET_EA;
                end
            end
            ST_GET_EA: begin
                if (data_out_window_in) begin
                    ea_nxt = data_bus_in;                     // RL18
                    phase_nxt = PH_W0;
                    state_nxt = ST_REQ;
                end
            end
            ST_REQ: begin
                if (request_window_in) begin
                    state_nxt = ST_ADDR;                      // RL2
                end
            end
            ST_ADDR: begin
                if (address_in_strobe_in && grant_in) begin
                    bus_nxt = step_addr_w;                    // RL3
                    fc_nxt = step_fc_w;                       // RL4
                    oe_n_nxt = 1'b0;
                    state_nxt = ST_DATA;
                end
            end
            ST_DATA: begin
                if (phase_r == PH_WR) begin
                    if (data_in_strobe_in) begin
                        bus_nxt = {2{char_r}};                // RL10
                        oe_n_nxt = 1'b0;
                        state_nxt = ST_TAIL;
                    end
                end else if (data_out_window_in) begin        // RL6
                    state_nxt = step_more_w ? ST_ADDR : ST_REQ;
                    case (phase_r)
                        PH_W0: begin
                            coc_nxt = data_bus_in[COC_HI:COC_LO];   // RL15
                            doc_nxt = data_bus_in[DOC_HI:DOC_LO];   // RL15
                            mask_nxt = data_bus_in[MASK_HI:MASK_LO];
                            start_nxt = 1'b1;                       // RL7
                            phase_nxt = PH_W3;
                            if (data_bus_in[COC_HI:COC_LO] == COC_NONE) begin
                                state_nxt = ST_DEV;
                            end
                        end
                        PH_W3: begin
                            ttb_nxt = data_bus_in;
                            phase_nxt = PH_W4;
                        end
                        PH_W4: begin
                            stb_nxt = data_bus_in;
                            state_nxt = ST_DEV;
                        end
                        PH_SRCH: begin
                            cond_set[COND_SRCH_BIT] = sel_byte_w[7];
                            phase_nxt = xlat_en_w ? PH_XLAT : PH_W1;
                        end
                        PH_XLAT: begin
                            char_nxt = sel_byte_w;
                            cond_set[COND_SRCH_BIT] = coc_r == COC_XLAT_INT && sel_byte_w[7];
                            phase_nxt = PH_W1;
                        end
                        PH_W1: begin
                            buf_nxt = data_bus_in;            // RL8
                            phase_nxt = PH_WR;
                        end
                        PH_W2: begin
                            state_nxt = ST_FLAG;
                            cnt_nxt = 3'(FLAG_WAIT_CYC);
                        end
                        default: begin
                            state_nxt = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_TAIL: begin
                if (request_window_in) begin
                    phase_nxt = PH_W2;                        // RL12
                    state_nxt = ST_ADDR;
                end
            end
            ST_FLAG: begin
                if (io_flag_window_in && io_flag_in) begin    // RL9
                    cond_set[COND_ZERO_BIT] = 1'b1;           // RL20
                    done_nxt = 1'b1;
                    phase_nxt = PH_W0;
                    state_nxt = doc_r[DOC_CHAIN_BIT] ? ST_REQ : ST_IDLE; // RL13
                end else if (io_flag_window_in || flag_cnt_r == 3'h0) begin
                    state_nxt = ST_DEV;
                end else begin
                    cnt_nxt = flag_cnt_r - 1'b1;
                end
            end
            ST_DEV: begin
                if (device_ready_in && fifo_valid_w) begin    // RL7
                    char_nxt = fifo_data_w;
                    pop_w = 1'b1;
                    phase_nxt = srch_en_w ? PH_SRCH : xlat_en_w ? PH_XLAT : PH_W1; // RL14
                    state_nxt = ST_REQ;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (stop_cmd_w) begin
            state_nxt = ST_IDLE;                              // RL19
            oe_n_nxt = 1'b1;
            fc_nxt = FC_NONE;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            state_r <= ST_IDLE;
            phase_r <= PH_W0;
            ea_r <= RESET_WORD;
            buf_addr_r <= RESET_WORD;
            stb_r <= RESET_WORD;
            ttb_r <= RESET_WORD;
            bus_out_r <= RESET_WORD;
        end else begin
            state_r <= state_nxt;
            phase_r <= phase_nxt;
            ea_r <= ea_nxt;
            buf_addr_r <= buf_nxt;
            stb_r <= stb_nxt;
            ttb_r <= ttb_nxt;
            bus_out_r <= bus_nxt;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            char_r <= RESET_BYTE;
            mask_r <= RESET_BYTE;
            cond_r <= RESET_BYTE;
            coc_r <= COC_NONE;
            doc_r <= 5'h00;
            fc_r <= FC_NONE;
            flag_cnt_r <= 3'h0;
            oe_n_r <= 1'b1;
            start_r <= 1'b0;
            stop_r <= 1'b0;
            done_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            char_r <= char_nxt;
            mask_r <= mask_nxt;
            cond_r <= cond_nxt;
            coc_r <= coc_nxt;
            doc_r <= doc_nxt;
            fc_r <= fc_nxt;
            flag_cnt_r <= cnt_nxt;
            oe_n_r <= oe_n_nxt;
            start_r <= start_nxt;
            stop_r <= stop_cmd_w;
            done_r <= done_nxt;
            irq_r <= |(cond_r & mask_r);                      // RL21
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_grant;
        state_r == ST_ADDR && address_in_strobe_in && grant_in;
    endsequence
    sequence s_write_strobe;
        state_r == ST_DATA && phase_r == PH_WR && data_in_strobe_in;
    endsequence

    AST_REQ_IN_WINDOW: assert property (cycle_request_out |-> request_window_in) // RL2
        else $error("cycle request outside request window");
    AST_ADDR_DRIVE: assert property (s_grant |=> !data_bus_oe_n_out // RL3
        && data_bus_out == $past(step_addr_w) && function_code_out == $past(step_fc_w))
        else $error("address or function code not driven after grant");
    AST_NO_GRANT: assert property (state_r == ST_ADDR && !grant_in |=> data_bus_oe_n_out) // RL3
        else $error("bus driven without grant");
    AST_FC_WITH_ADDR: assert property (function_code_out != FC_NONE |-> !data_bus_oe_n_out) // RL4
        else $error("function code without address on bus");
    AST_WRITE_BYTE: assert property (s_write_strobe |=> !data_bus_oe_n_out // RL10
        && data_bus_out == {2{$past(char_r)}} ##1 data_bus_oe_n_out)
        else $error("data byte not driven for one cycle after data-in");
    AST_DROP_LAST: assert property (state_r == ST_DATA && phase_r == PH_W2 // RL11
        && request_window_in |-> !cycle_request_out)
        else $error("request held at final step window");
    AST_KEEP_MULTI: assert property (state_r == ST_DATA && phase_r == PH_W1 // RL11
        && request_window_in |-> cycle_request_out)
        else $error("request dropped inside multistep sequence");
    AST_ORDER_DECODE: assert property (state_r == ST_DATA && phase_r == PH_W0 // RL15
        && data_out_window_in |=> device_start_out
        && device_order_out == $past(data_bus_in[DOC_HI:DOC_LO]))
        else $error("order byte not decoded");
    AST_BUF_ADDR: assert property (state_r == ST_DATA && phase_r == PH_W1 // RL12
        && data_out_window_in |=> phase_r == PH_WR && buf_addr_r == $past(data_bus_in))
        else $error("buffer address not taken");
    AST_SELECT: assert property (device_address_window_in && state_r == ST_IDLE // RL1
        && data_bus_in[DEV_HI:DEV_LO] != dev_sel_in |=> state_r == ST_IDLE)
        else $error("started for another peripheral");
    AST_STOP: assert property (stop_cmd_w |=> state_r == ST_IDLE && device_stop_out // RL19
        && data_bus_oe_n_out)
        else $error("stop not obeyed");
    AST_FLAG_END: assert property (state_r == ST_FLAG && io_flag_window_in && io_flag_in // RL13
        && !chain_req_out |=> state_r == ST_IDLE && condition_out[COND_ZERO_BIT] && done_out)
        else $error("count zero flag did not end transfer");
endmodule

/* File: hw/io_chan_pkg.sv */
// Purpose: shared constants and types of the i/o bus channel controller
// Assumes: bit 0 of a bus word in the field map is the most significant bit
// Notes: bit positions below are already turned to vector indices
package io_chan_pkg;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    // device address window word
    localparam int CMD_HI = 15;
    localparam int CMD_LO = 12;
    localparam int CTL_HI = 11;
    localparam int CTL_LO = 5;
    localparam int SUB_HI = 4;
    localparam int SUB_LO = 2;
    localparam int DEV_HI = 1;
    localparam int DEV_LO = 0;
    localparam logic [3:0] CMD_START = 4'h0;
    localparam logic [3:0] CMD_STOP = 4'h1;
    // packet word 0
    localparam int COC_HI = 15;
    localparam int COC_LO = 13;
    localparam int DOC_HI = 12;
    localparam int DOC_LO = 8;
    localparam int MASK_HI = 7;
    localparam int MASK_LO = 0;
    localparam int DOC_CHAIN_BIT = 4;
    localparam logic [2:0] COC_NONE = 3'h0;
    localparam logic [2:0] COC_XLAT = 3'h1;
    localparam logic [2:0] COC_XLAT_INT = 3'h5;
    localparam logic [2:0] COC_SRCH = 3'h6;
    localparam logic [2:0] COC_BOTH = 3'h7;
    // function codes
    localparam logic [2:0] FC_NONE = 3'h0;
    localparam logic [2:0] FC_READ = 3'h1;
    localparam logic [2:0] FC_WRITE = 3'h3;
    localparam logic [2:0] FC_FETCH_INC = 3'h4;
    // packet word byte offsets
    localparam logic [15:0] PKT_W1_OFS = 16'h0002;
    localparam logic [15:0] PKT_W2_OFS = 16'h0004;
    localparam logic [15:0] PKT_W3_OFS = 16'h0006;
    localparam logic [15:0] PKT_W4_OFS = 16'h0008;
    // condition byte bits
    localparam int COND_SRCH_BIT = 0;
    localparam int COND_ZERO_BIT = 1;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    // wait for the flag window after the byte count fetch
    localparam int CLK_PERIOD_NS = 8;
    localparam int FLAG_WAIT_NS = 32;
    localparam int FLAG_WAIT_CYC = FLAG_WAIT_NS / CLK_PERIOD_NS;
    typedef enum logic [2:0] {
        ST_IDLE, ST_GET_EA, ST_REQ, ST_ADDR, ST_DATA, ST_TAIL, ST_FLAG, ST_DEV
    } state_type;
    typedef enum logic [2:0] {
        PH_W0, PH_W3, PH_W4, PH_SRCH, PH_XLAT, PH_W1, PH_WR, PH_W2
    } phase_type;
endpackage

/* File: bench/io_proc_model.sv */
// Purpose: processor and memory model on the far side of the i/o bus
// Assumes: sole requester, so grant stays high except for one refused strobe per step when slow
// Notes: word at even byte address a is {mem[a], mem[a+1]}
`timescale 1ns/1ns

module io_proc_model
    import io_chan_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic slow_in,
    input wire logic cycle_request_in,
    input wire logic [2:0] function_code_in,
    input wire logic [15:0] drv_in,
    input wire logic oe_n_in,
    output logic [15:0] bus_out,
    output logic [5:0] strobe_out,
    output logic io_flag_out,
    output logic grant_out
);
    logic [7:0] mem [0:1023];
    logic [15:0] drv_r = 16'h0000;
    logic drv_en_r = 1'b0;
    logic dio_pend = 1'b0;
    logic more;
    logic [15:0] dio_word, dio_ea, addr, word;
    logic [2:0] fc;
    logic [9:0] wa;
    // released bus shows the inverse of the last value driven
    assign bus_out = !oe_n_in ? drv_in : drv_en_r ? drv_r : ~drv_r;
    // strobe bits: 0 request, 1 address-in, 2 device address, 3 data-in, 4 data-out, 5 flag
    task automatic pulse(input int k);
        strobe_out[k] <= 1'b1;
        @(posedge clk_in);
        strobe_out[k] <= 1'b0;
    endtask
    task automatic take();
        for (int n = 0; n < 8 && oe_n_in !== 1'b0; n++) @(posedge clk_in);
    endtask
    task automatic serve();
        more = 1'b1;
        while (more) begin
            if (slow_in) begin
                grant_out <= 1'b0;
                pulse(1);
                grant_out <= 1'b1;
                repeat (3) @(posedge clk_in);
            end
            pulse(1);
            take();
            addr = drv_in;
            fc = function_code_in;
            more = 1'b0;
            if (fc == FC_WRITE) begin
                pulse(3);
                take();
                mem[addr[9:0]] = addr[0] ? drv_in[7:0] : drv_in[15:8];
                pulse(0);
                more = cycle_request_in;
            end else if (fc == FC_READ || fc == FC_FETCH_INC) begin
                pulse(0);
                more = cycle_request_in;
                wa = {addr[9:1], 1'b0};
                word = {mem[wa], mem[wa + 10'd1]};
                drv_r <= word;
                drv_en_r <= 1'b1;
                pulse(4);
                drv_en_r <= 1'b0;
                if (fc == FC_FETCH_INC) begin
                    {mem[wa], mem[wa + 10'd1]} = word + 16'h0001;
                    io_flag_out <= &word;
                    if (&word) pulse(5);
                end
            end
            if (slow_in) repeat (4) @(posedge clk_in);
        end
    endtask
    task automatic do_io(input logic [15:0] w, input logic [15:0] ea);
        dio_word = w;
        dio_ea = ea;
        dio_pend = 1'b1;
        wait (dio_pend == 1'b0);
    endtask
    initial begin
        strobe_out = 6'h00;
        io_flag_out = 1'b0;
        grant_out = 1'b1;
        forever begin
            @(posedge clk_in);
            if (reset_n_in === 1'b1 && dio_pend) begin
                drv_r <= dio_word;
                drv_en_r <= 1'b1;
                pulse(2);
                drv_r <= dio_ea;
                if (dio_word[CMD_HI:CMD_LO] == CMD_START) pulse(4);
                drv_en_r <= 1'b0;
                dio_pend = 1'b0;
            end else if (reset_n_in === 1'b1) begin
                pulse(0);
                if (cycle_request_in === 1'b1) serve();
            end
        end
    end
endmodule

/* File: bench/testbench.sv */
// Purpose: self-checking bench of the i/o bus channel controller
// Assumes: io_proc_model serves every memory step
// Notes: straps fixed at controller 2a, subchannel 5
`timescale 1ns/1ns

module testbench;
    import io_chan_pkg::*;
    logic core_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic device_ready_in = 1'b0;
    logic byte_valid_in = 1'b0;
    logic [7:0] byte_in = 8'h00;
    logic interrupt_clear_in = 1'b0;
    logic slow = 1'b0;
    logic [1:0] dev_sel = 2'h1;
    logic [5:0] strobe;
    logic [15:0] bus, drv;
    logic [4:0] device_order_out;
    logic [2:0] fc;
    logic [7:0] condition_out;
    logic io_flag, grant, cyc_req, oe_n, chain_req_out, device_start_out, device_stop_out;
    logic byte_ready_out, busy_out, done_out, interrupt_out;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    io_channel_ctrl #(.FIFO_DEPTH(32)) uut (
        .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .ctl_addr_in(7'h2a),
        .subchan_in(3'h5), .dev_sel_in(dev_sel), .device_address_window_in(strobe[2]),
        .request_window_in(strobe[0]), .address_in_strobe_in(strobe[1]),
        .data_in_strobe_in(strobe[3]), .data_out_window_in(strobe[4]), .io_flag_in(io_flag),
        .io_flag_window_in(strobe[5]), .grant_in(grant), .data_bus_in(bus), .data_bus_out(drv),
        .data_bus_oe_n_out(oe_n), .function_code_out(fc), .cycle_request_out(cyc_req),
        .device_order_out(device_order_out), .chain_req_out(chain_req_out),
        .device_start_out(device_start_out), .device_stop_out(device_stop_out),
        .device_ready_in(device_ready_in), .byte_valid_in(byte_valid_in), .byte_in(byte_in),
        .byte_ready_out(byte_ready_out), .busy_out(busy_out), .done_out(done_out),
        .condition_out(condition_out), .interrupt_out(interrupt_out),
        .interrupt_clear_in(interrupt_clear_in));
    io_proc_model proc (
        .clk_in(core_clk_in), .reset_n_in(reset_n_in), .slow_in(slow), .cycle_request_in(cyc_req),
        .function_code_in(fc), .drv_in(drv), .oe_n_in(oe_n), .bus_out(bus), .strobe_out(strobe),
        .io_flag_out(io_flag), .grant_out(grant));
    initial forever #4 core_clk_in = ~core_clk_in;
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            $display("[FAIL] %0t timeout", $time);
            end_of_test();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask
    // sel: 0 done, 1 device stop, 2 device start
    task automatic wait_hi(input int sel, input int lim);
        int k = 0;
        while (k < lim && (sel == 0 ? done_out : sel == 1 ? device_stop_out
                : device_start_out) !== 1'b1) begin
            tick(1);
            k++;
        end
        check(16'(k < lim), 16'h0001);
    endtask
    task automatic push(input int n, input logic [7:0] first, input logic [7:0] step);
        byte_valid_in <= 1'b1;
        for (int i = 0; i < n; i++) begin
            byte_in <= first + step * 8'(i);
            do tick(1); while (byte_ready_out !== 1'b1);
        end
        byte_valid_in <= 1'b0;
        tick(1);
    endtask
    task automatic set_w(input int a, input logic [15:0] v);
        {proc.mem[a], proc.mem[a + 1]} = v;
    endtask
    function automatic logic [15:0] mw(input int a);
        return {proc.mem[a], proc.mem[a + 1]};
    endfunction
    function automatic logic [15:0] device_address_window(input logic [3:0] cmd, input logic [1:0] dev);
        return {cmd, 7'h2a, 3'h5, dev};
    endfunction
    initial begin
        tick(16);
        reset_n_in <= 1'b1;
        tick(2);
        check({oe_n, busy_out, byte_ready_out, condition_out}, {3'b101, 8'h00});
        // fill the buffer while the device is not ready, then move 32 bytes
        set_w(16'h0100, 16'h0302);
        set_w(16'h0102, 16'h0200);
        set_w(16'h0104, 16'hffe0);
        push(32, 8'h03, 8'h07);
        check(16'(byte_ready_out), 16'h0000);
        proc.do_io(device_address_window(CMD_START, 2'h1), 16'h0100);
        wait_hi(2, 60);
        tick(30);
        check({device_order_out, chain_req_out, busy_out}, {5'h03, 2'b01});
        device_ready_in <= 1'b1;
        wait_hi(0, 5000);
        tick(2);
        for (int i = 0; i < 32; i++) check(16'(proc.mem[16'h0200 + i]), 16'(8'h03 + 8'h07 * i));
        check(mw(16'h0102), 16'h0220);
        check(mw(16'h0104), 16'h0000);
        check({condition_out, interrupt_out, byte_ready_out}, {8'h02, 2'b11});
        interrupt_clear_in <= 1'b1;
        tick(1);
        interrupt_clear_in <= 1'b0;
        tick(3);
        check({condition_out, interrupt_out, busy_out}, 16'h0000);
        // search then translate, chained, slow processor
        slow <= 1'b1;
        for (int c = 0; c < 128; c++) begin
            proc.mem[16'h0300 + c] = 8'(c) ^ 8'h20;
            proc.mem[16'h0380 + c] = (c == 16'h0042) ? 8'h80 : 8'h00;
        end
        set_w(16'h0140, 16'hf201);
        set_w(16'h0142, 16'h0280);
        set_w(16'h0144, 16'hfffe);
        set_w(16'h0146, 16'h0300);
        set_w(16'h0148, 16'h0380);
        proc.do_io(device_address_window(CMD_START, 2'h1), 16'h0140);
        push(2, 8'h41, 8'h01);
        wait_hi(0, 5000);
        check(mw(16'h0280), 16'h6162);
        check({device_order_out, chain_req_out}, {5'h12, 1'b1});
        tick(100);
        check({condition_out, interrupt_out, busy_out}, {8'h03, 2'b11});
        proc.do_io(device_address_window(CMD_STOP, 2'h1), 16'h0000);
        wait_hi(1, 10);
        tick(2);
        check({busy_out, oe_n}, 16'h0001);
        // peripheral select must match the strap
        proc.do_io(device_address_window(CMD_START, 2'h2), 16'h0100);
        tick(20);
        check(16'(busy_out), 16'h0000);
        dev_sel <= 2'h2;
        proc.do_io(device_address_window(CMD_START, 2'h2), 16'h0100);
        tick(20);
        check(16'(busy_out), 16'h0001);
        end_of_test();
    end
endmodule
